// >>> include/swl_defines.svh
// Constants for the split-wire line link slave
`ifndef SWL_DEFINES_SVH
`define SWL_DEFINES_SVH

// Frame layout: 32 bits per direction, four bytes, MSB first
`define SWL_FRAME_BITS     32
`define SWL_BYTE_BITS      8
`define SWL_CNT_W          6
`define SWL_BIT_FIRST      6'h00
`define SWL_BYTE_LAST      6'h07
`define SWL_BIT_LAST       6'h1F
`define SWL_PHASE_DONE     6'h20

// Reset values
`define SWL_TX_RESET       32'h0000_0000
`define SWL_RX_RESET       32'h0000_0000
`define SWL_ID_RESET       8'h00

// Timing: system clock period and frame period in ns
`define SWL_SYS_NS         20
`define SWL_FRAME_NS       125000
`define SWL_TIMEOUT_FRAMES 2
`define SWL_TIMEOUT_CYC \
   (`SWL_TIMEOUT_FRAMES * `SWL_FRAME_NS / `SWL_SYS_NS)

// Positions in the system-side synchronizer vector
`define SWL_SI_ONE_WIRE    0
`define SWL_SI_PRESENT     1
`define SWL_SI_RX          2
`define SWL_SI_ID          3
`define SWL_SI_REQ         4
`define SWL_SI_W           5

`endif

// >>> include/swl_pkg.sv
// Types shared by the split-wire line link slave
package swl_pkg;
   // Health of the link as seen from the system clock
   typedef enum logic [1:0] {
      swl_st_idle    = 2'b00,
      swl_st_wait_id = 2'b01,
      swl_st_up      = 2'b10
   } swl_link_state_t;
endpackage

// >>> design/swl_pin_sync.sv
// Three-stage level synchronizer with agreement filter
`timescale 1ns/10ps
module swl_pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset of the receiving domain
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Level from another domain or a pin
   input  wire logic [WIDTH-1:0] d_in,
   // Filtered level, from a flip-flop
   output logic      [WIDTH-1:0] lvl_out
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
         logic [2:0] stage;     // Synchronizer stages, first at bit 0
         logic       next_lvl;  // Level once stages two and three agree

         // Adopt a new level only when the last two stages agree
         always_comb begin
            next_lvl = lvl_out[g];
            if (stage[1] == stage[2]) begin
               next_lvl = stage[2];
            end
         end

         // Stage one is read only by stage two
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               stage      <= 3'h0;
               lvl_out[g] <= 1'b0;
            end else begin
               stage      <= {stage[1:0], d_in[g]};
               lvl_out[g] <= next_lvl;
            end
         end
      end
   endgenerate
endmodule

// >>> design/swl_link_slave.sv
// Split-wire line link slave: frame shifter, id capture, straps
//
// What this block does
// - Send outgoing frame bytes on transmit wire
// - One-wire mode: transmit wire turns with strobe
// - Sample wire-count strap, pick wire mode
// - Strap low means one-wire operation
// - Capture identification byte for firmware
// - Hold far end in reset with us
// - Present installed-sense line as status
// - 32 bits each way, MSB first
// - Transmit wire valid only while strobe high in two-wire, only while strobe low in one-wire
`timescale 1ns/10ps
`include "swl_defines.svh"
module swl_link_slave #(
   parameter int TIMEOUT_CYC = `SWL_TIMEOUT_CYC
) (
   // System clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        resetn,
   // Link clock and direction strobe from the line unit
   input  wire logic                        clk_link,
   input  wire logic                        link_direction_strobe,
   // Transmit wire, two-way in one-wire operation
   input  wire logic                        line_data_link_in,
   output logic                             line_data_link_out,
   output logic                             line_data_link_oe,
   // Receive wire from the line unit
   input  wire logic                        line_rx_data,
   // Reset toward the line unit
   output logic                             line_unit_reset_out,
   // Strap and sense lines
   input  wire logic                        wire_count_strap_n,
   input  wire logic                        bulkhead_present_n,
   // Frame words on the system side
   input  wire logic [`SWL_FRAME_BITS-1:0]  tx_frame,
   output logic                             tx_taken,
   output logic      [`SWL_FRAME_BITS-1:0]  rx_frame,
   output logic                             rx_frame_valid,
   // Identification and status
   output logic      [`SWL_BYTE_BITS-1:0]   id_byte,
   output logic                             id_valid,
   output logic                             one_wire_mode,
   output logic                             bulkhead_present,
   output swl_pkg::swl_link_state_t         link_state
);
   import swl_pkg::*;

   localparam int TO_W = $clog2(TIMEOUT_CYC + 1);

   // ---------------- Link clock domain ----------------

   logic [1:0]                  lrst_q;       // Link reset release chain
   logic                        link_rst_n;   // Link-domain reset
   logic                        link_one_wire; // Wire mode in link domain
   logic                        strobe_q;     // Strobe seen last edge
   logic [`SWL_CNT_W-1:0]       cnt;          // Bit index in phase
   logic [`SWL_FRAME_BITS-1:0]  send_sh;      // Outgoing shifter
   logic [`SWL_FRAME_BITS-1:0]  recv_sh;      // Incoming shifter
   logic [`SWL_BYTE_BITS-1:0]   id_sh;        // Identification shifter
   logic                        sent_first;   // First byte sent
   logic                        id_armed;     // This phase carries id
   logic                        id_done;      // Id byte taken
   logic [`SWL_FRAME_BITS-1:0]  rx_word;      // Last received word
   logic [`SWL_BYTE_BITS-1:0]   id_word;      // Received id byte
   logic                        rx_tgl;       // Flips per received word
   logic                        id_tgl;       // Flips once for id
   logic                        req_tgl;      // Flips per word loaded
   logic [`SWL_FRAME_BITS-1:0]  tx_hold;      // Word held for the link

   logic                        phase_start;  // Strobe changed
   logic [`SWL_CNT_W-1:0]       idx;          // Index of current bit
   logic                        active;       // Phase not finished
   logic                        send_now;     // We own the wire
   logic                        recv_bit;     // Incoming data bit
   logic                        id_go;        // Shift an id bit
   logic                        next_strobe_q;
   logic [`SWL_CNT_W-1:0]       next_cnt;
   logic [`SWL_FRAME_BITS-1:0]  next_send_sh;
   logic [`SWL_FRAME_BITS-1:0]  next_recv_sh;
   logic [`SWL_BYTE_BITS-1:0]   next_id_sh;
   logic                        next_sent_first;
   logic                        next_id_armed;
   logic                        next_id_done;
   logic [`SWL_FRAME_BITS-1:0]  next_rx_word;
   logic [`SWL_BYTE_BITS-1:0]   next_id_word;
   logic                        next_rx_tgl;
   logic                        next_id_tgl;
   logic                        next_req_tgl;
   logic                        next_tx_out;
   logic                        next_tx_oe;

   // Link reset asserts at once and releases on the second link edge
   always_ff @(posedge clk_link or negedge resetn) begin
      if (!resetn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end
   assign link_rst_n = lrst_q[1];

   // Wire mode crosses from the system domain as a level
   swl_pin_sync #(.WIDTH(1)) u_mode_sync (
      .clk     (clk_link),
      .rst_n   (link_rst_n),
      .d_in    (one_wire_mode),
      .lvl_out (link_one_wire)
   );

   // Bit engine: both parties clock bits on the far end's link clock
   always_comb begin
      phase_start     = link_direction_strobe != strobe_q;
      idx             = phase_start ? `SWL_BIT_FIRST : cnt;
      active          = idx < `SWL_PHASE_DONE;
      // Two-wire: drive while strobe high
      // One-wire: drive while strobe low, listen while high
      send_now        = link_one_wire ? !link_direction_strobe
                                      : link_direction_strobe;
      // Incoming data: own wire in two-wire, shared wire in one-wire
      recv_bit        = link_one_wire ? line_data_link_in : line_rx_data;
      next_strobe_q   = link_direction_strobe;
      next_cnt        = active ? idx + 6'h01 : cnt;
      next_send_sh    = send_sh;
      next_recv_sh    = recv_sh;
      next_id_sh      = id_sh;
      next_sent_first = sent_first;
      next_id_done    = id_done;
      next_rx_word    = rx_word;
      next_id_word    = id_word;
      next_rx_tgl     = rx_tgl;
      next_id_tgl     = id_tgl;
      next_req_tgl    = req_tgl;
      next_tx_out     = 1'b0;
      next_tx_oe      = 1'b0;
      if (send_now && active) begin
         // Outgoing word, MSB first, on the transmit wire
         next_tx_oe = 1'b1;
         if (idx == `SWL_BIT_FIRST) begin
            next_tx_out  = tx_hold[`SWL_FRAME_BITS-1];
            next_send_sh = {tx_hold[`SWL_FRAME_BITS-2:0], 1'b0};
            next_req_tgl = ~req_tgl;
         end else begin
            next_tx_out  = send_sh[`SWL_FRAME_BITS-1];
            next_send_sh = {send_sh[`SWL_FRAME_BITS-2:0], 1'b0};
         end
         // First byte out invites the identification byte
         if (idx == `SWL_BYTE_LAST) begin
            next_sent_first = 1'b1;
         end
      end
      if (!send_now && active) begin
         // Incoming word, MSB first, 32 bits
         next_recv_sh = {recv_sh[`SWL_FRAME_BITS-2:0], recv_bit};
         if (idx == `SWL_BIT_LAST) begin
            next_rx_word = next_recv_sh;
            next_rx_tgl  = ~rx_tgl;
         end
      end
      // Id is taken on the receive wire in a strobe-low phase that
      // starts after our first byte went out
      if (phase_start) begin
         next_id_armed = !link_direction_strobe && sent_first && !id_done;
      end else begin
         next_id_armed = id_armed;
      end
      id_go = active && !link_direction_strobe && !id_done
              && (phase_start ? next_id_armed : id_armed);
      if (id_go) begin
         next_id_sh = {id_sh[`SWL_BYTE_BITS-2:0], line_rx_data};
         if (idx == `SWL_BYTE_LAST) begin
            next_id_word  = next_id_sh;
            next_id_tgl   = ~id_tgl;
            next_id_done  = 1'b1;
            next_id_armed = 1'b0;
         end
      end
   end

   // Link-domain registers
   always_ff @(posedge clk_link or negedge link_rst_n) begin
      if (!link_rst_n) begin
         strobe_q           <= 1'b0;
         cnt                <= `SWL_PHASE_DONE;
         send_sh            <= `SWL_TX_RESET;
         recv_sh            <= `SWL_RX_RESET;
         id_sh              <= `SWL_ID_RESET;
         sent_first         <= 1'b0;
         id_armed           <= 1'b0;
         id_done            <= 1'b0;
         rx_word            <= `SWL_RX_RESET;
         id_word            <= `SWL_ID_RESET;
         rx_tgl             <= 1'b0;
         id_tgl             <= 1'b0;
         req_tgl            <= 1'b0;
         line_data_link_out <= 1'b0;
         line_data_link_oe  <= 1'b0;
      end else begin
         strobe_q           <= next_strobe_q;
         cnt                <= next_cnt;
         send_sh            <= next_send_sh;
         recv_sh            <= next_recv_sh;
         id_sh              <= next_id_sh;
         sent_first         <= next_sent_first;
         id_armed           <= next_id_armed;
         id_done            <= next_id_done;
         rx_word            <= next_rx_word;
         id_word            <= next_id_word;
         rx_tgl             <= next_rx_tgl;
         id_tgl             <= next_id_tgl;
         req_tgl            <= next_req_tgl;
         line_data_link_out <= next_tx_out;
         line_data_link_oe  <= next_tx_oe;
      end
   end

   // Two-wire: transmit wire released while strobe is low
   a_oe_two_wire: assert property (@(posedge clk_link)
      disable iff (!link_rst_n)
      (!link_one_wire && !link_direction_strobe) [*2]
      |-> !line_data_link_oe)
      else $error("transmit wire driven with strobe low");

   // One-wire: we listen while the far end drives toward us
   a_oe_one_wire: assert property (@(posedge clk_link)
      disable iff (!link_rst_n)
      (link_one_wire && link_direction_strobe) [*2]
      |-> !line_data_link_oe)
      else $error("shared wire driven while far end sends");

   // Outgoing word starts with its most significant bit
   a_msb_first: assert property (@(posedge clk_link)
      disable iff (!link_rst_n)
      phase_start && send_now
      |=> line_data_link_oe
          && line_data_link_out == $past(tx_hold[`SWL_FRAME_BITS-1]))
      else $error("first bit out is not the word MSB");

   // A word is delivered only after its 32nd bit
   a_word_length: assert property (@(posedge clk_link)
      disable iff (!link_rst_n)
      $changed(rx_tgl) |-> cnt == `SWL_PHASE_DONE)
      else $error("word delivered at wrong bit count");

   // Identification is taken once only
   a_id_once: assert property (@(posedge clk_link)
      disable iff (!link_rst_n)
      id_done |=> $stable(id_tgl) && $stable(id_word))
      else $error("identification taken twice");

   // ---------------- System clock domain ----------------

   logic [`SWL_SI_W-1:0] sys_raw;    // Levels entering the synchronizer
   logic [`SWL_SI_W-1:0] sys_lvl;    // Filtered levels
   logic [2:0]           tgl_seen;   // Toggle levels already handled
   logic                 rx_evt;     // New received word
   logic                 id_evt;     // Identification arrived
   logic                 req_evt;    // Link loaded the held word
   logic [TO_W-1:0]      idle_cnt;   // Cycles since last link frame
   logic                 timed_out;  // Link went quiet
   logic [2:0]           next_tgl_seen;
   logic [`SWL_FRAME_BITS-1:0] next_tx_hold;
   logic [`SWL_FRAME_BITS-1:0] next_rx_frame;
   logic [`SWL_BYTE_BITS-1:0]  next_id_byte;
   logic                 next_id_valid;
   logic [TO_W-1:0]      next_idle_cnt;
   swl_link_state_t      next_link_state;

   // Straps, sense and link toggles pass three stages and a filter flop
   assign sys_raw = {req_tgl, id_tgl, rx_tgl,
                     ~bulkhead_present_n, ~wire_count_strap_n};

   swl_pin_sync #(.WIDTH(`SWL_SI_W)) u_sys_sync (
      .clk     (clk_sys),
      .rst_n   (resetn),
      .d_in    (sys_raw),
      .lvl_out (sys_lvl)
   );

   // Low strap selects one-wire; sense low means bulkhead in place
   assign one_wire_mode    = sys_lvl[`SWL_SI_ONE_WIRE];
   assign bulkhead_present = sys_lvl[`SWL_SI_PRESENT];

   // Word handover, id capture and link health
   always_comb begin
      rx_evt  = sys_lvl[`SWL_SI_RX] != tgl_seen[0];
      id_evt  = sys_lvl[`SWL_SI_ID] != tgl_seen[1];
      req_evt = sys_lvl[`SWL_SI_REQ] != tgl_seen[2];
      next_tgl_seen = sys_lvl[`SWL_SI_REQ:`SWL_SI_RX];
      // Link word stays stable for a whole phase after its toggle
      next_rx_frame = rx_evt ? rx_word : rx_frame;
      // New word is held until the link loads it a frame later
      next_tx_hold  = req_evt ? tx_frame : tx_hold;
      // Id kept from first capture until reset
      next_id_byte  = (id_evt && !id_valid) ? id_word : id_byte;
      next_id_valid = id_valid || id_evt;
      timed_out     = idle_cnt == TO_W'(TIMEOUT_CYC - 1);
      next_idle_cnt = (req_evt || timed_out) ? '0 : idle_cnt + 1'b1;
      next_link_state = link_state;
      case (link_state)
         swl_st_idle: begin
            if (req_evt) begin
               next_link_state = id_valid ? swl_st_up : swl_st_wait_id;
            end
         end
         swl_st_wait_id: begin
            if (timed_out) begin
               next_link_state = swl_st_idle;
            end else if (id_evt) begin
               next_link_state = swl_st_up;
            end
         end
         swl_st_up: begin
            if (timed_out) begin
               next_link_state = swl_st_idle;
            end
         end
         default: begin
            next_link_state = swl_st_idle;
         end
      endcase
   end

   // System-domain registers; far-end reset follows ours
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         tgl_seen            <= 3'h0;
         tx_hold             <= `SWL_TX_RESET;
         tx_taken            <= 1'b0;
         rx_frame            <= `SWL_RX_RESET;
         rx_frame_valid      <= 1'b0;
         id_byte             <= `SWL_ID_RESET;
         id_valid            <= 1'b0;
         idle_cnt            <= '0;
         link_state          <= swl_st_idle;
         line_unit_reset_out <= 1'b1;
      end else begin
         tgl_seen            <= next_tgl_seen;
         tx_hold             <= next_tx_hold;
         tx_taken            <= req_evt;
         rx_frame            <= next_rx_frame;
         rx_frame_valid      <= rx_evt;
         id_byte             <= next_id_byte;
         id_valid            <= next_id_valid;
         idle_cnt            <= next_idle_cnt;
         link_state          <= next_link_state;
         line_unit_reset_out <= 1'b0;
      end
   end

   // Far end is held in reset while we are
   a_reset_line: assert property (@(posedge clk_sys)
      !resetn |=> line_unit_reset_out)
      else $error("line unit reset not asserted in reset");

   // And released once we run
   a_reset_release: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      $past(resetn) |-> !line_unit_reset_out)
      else $error("line unit reset stuck after release");

   // Grounded strap shows as one-wire four cycles later
   a_mode_strap: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      $fell(wire_count_strap_n) ##1 (!wire_count_strap_n) [*4]
      |-> one_wire_mode)
      else $error("grounded strap not seen as one-wire");

   // Released sense line shows as absent four cycles later
   a_present_sense: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      $rose(bulkhead_present_n) ##1 bulkhead_present_n [*4]
      |-> !bulkhead_present)
      else $error("bulkhead removal not reported");

   // Captured id never changes before reset
   a_id_stable: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      id_valid |=> id_valid && $stable(id_byte))
      else $error("identification byte changed");

   // Each received word is announced for one cycle
   a_rx_pulse: assert property (@(posedge clk_sys)
      disable iff (!resetn)
      rx_frame_valid |=> !rx_frame_valid && $stable(rx_frame))
      else $error("received word pulse too long");
endmodule

// >>> tb/swl_line_master.sv
// Line unit model: link clock, strobe, frames and id toward the slave
`timescale 1ns/10ps
module swl_line_master (
   // Control from the bench
   input  wire logic        resetn,
   input  wire logic        run,
   input  wire logic        one_wire,
   input  wire logic [31:0] word_out,
   // Link pins
   output logic             clk_link,
   output logic             strobe,
   output logic             rx_data,
   output logic             wire_lvl,
   input  wire logic        dut_out,
   input  wire logic        dut_oe,
   // Results for the bench
   output logic [31:0]      seen,
   output int               frames,
   output int               n_bad
);
   logic        m_oe;   // We drive the transmit wire
   logic        m_out;  // Our bit on the transmit wire
   logic        park;   // Released wire flips every period
   logic [31:0] acc;    // Word gathered from the slave
   int          s;      // First index of the slave's send phase

   // Wire level from both parties' enables
   assign wire_lvl = dut_oe ? dut_out : (m_oe ? m_out : park);

   // Start idle with the clock standing still
   initial begin
      {clk_link, strobe, rx_data, m_oe, m_out, park} = 6'h00;
      acc = 32'h0000_0000;
      seen = 32'h0000_0000;
      s = 0;
      frames = 0;
      n_bad = 0;
   end

   // One link period; the slave's bit k is taken at edge k+1
   task automatic tick(input int i);
      begin
         if (i - s >= 1 && i - s <= 32) begin
            acc = {acc[30:0], wire_lvl};
         end else if (dut_oe) begin
            n_bad++;
         end
         park = ~wire_lvl;
         #24 clk_link = 1'b1;
         #24 clk_link = 1'b0;
      end
   endtask

   // Reset edges, preamble, then whole frames while asked
   always begin
      if (!resetn) begin
         tick(-100);
      end else if (run) begin
         repeat (8) tick(-100);
         while (run) begin
            s = one_wire ? 32 : 0;
            for (int i = 0; i < 68; i++) begin
               strobe = (i < 32);
               m_oe = one_wire && (i < 32);
               // Wire word is inverted so it differs from the rx word
               m_out = ~word_out[31 - i % 32];
               rx_data = (i >= 32 && i < 64) ?
                  word_out[31 - i % 32] : ~rx_data;
               tick(i);
            end
            seen = acc;
            frames++;
            #100;
         end
      end else begin
         @(resetn or run);
      end
   end
endmodule

// >>> tb/swl_link_slave_tb.sv
// Bench for the split-wire line link slave
`timescale 1ns/10ps
`include "swl_defines.svh"
`define CHK(nm, exp, got) \
   begin \
      check_count++; \
      if ((got) !== (exp)) begin \
         n_mismatch++; \
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); \
      end \
   end
module swl_link_slave_tb;
   import swl_pkg::*;
   logic        clk_sys, resetn, run, strap_n, present_n;
   logic [31:0] tx_frame, word_out, seen, rx_frame;
   logic        clk_link, strobe, rx_data, wire_lvl, d_out, d_oe, rst_out;
   logic        tx_taken, rx_valid, id_valid, one_wire_mode, present;
   logic [7:0]  id_byte;
   swl_link_state_t link_state;
   int          frames, n_bad, n_mismatch, check_count;
   int          n_taken = 0;  // Cycles with tx_taken high
   int          n_rxv = 0;    // Cycles with rx_frame_valid high
   // Rows: strap_n, present_n, expected one_wire_mode, present
   logic [3:0]  rows [4] = '{4'hC, 4'h6, 4'h9, 4'h3};

   // System clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   swl_line_master u_line (.resetn(resetn), .run(run),
      .one_wire(!strap_n), .word_out(word_out), .clk_link(clk_link),
      .strobe(strobe), .rx_data(rx_data), .wire_lvl(wire_lvl),
      .dut_out(d_out), .dut_oe(d_oe), .seen(seen), .frames(frames),
      .n_bad(n_bad));

   swl_link_slave #(.TIMEOUT_CYC(200)) u_dut (.clk_sys(clk_sys),
      .resetn(resetn), .clk_link(clk_link),
      .link_direction_strobe(strobe), .line_data_link_in(wire_lvl),
      .line_data_link_out(d_out), .line_data_link_oe(d_oe),
      .line_rx_data(rx_data), .line_unit_reset_out(rst_out),
      .wire_count_strap_n(strap_n), .bulkhead_present_n(present_n),
      .tx_frame(tx_frame), .tx_taken(tx_taken), .rx_frame(rx_frame),
      .rx_frame_valid(rx_valid), .id_byte(id_byte), .id_valid(id_valid),
      .one_wire_mode(one_wire_mode), .bulkhead_present(present),
      .link_state(link_state));

   task automatic give_verdict;
      begin
         if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask

   // Reset pulse; the line unit must follow it
   task automatic do_reset;
      begin
         resetn <= 1'b0;
         repeat (8) @(posedge clk_sys);
         `CHK("reset_out", 1'b1, rst_out)
         `CHK("id_valid", 1'b0, id_valid)
         resetn <= 1'b1;
         repeat (4) @(posedge clk_sys);
         #1;
         `CHK("reset_out_rel", 1'b0, rst_out)
      end
   endtask

   // One whole frame with the given word from the line unit
   task automatic run_frame(input logic [31:0] w);
      int f0;
      begin
         f0 = frames;
         @(posedge clk_sys);
         word_out <= w;
         run <= 1'b1;
         for (int t = 0; t < 400 && frames == f0; t++) @(posedge clk_sys);
         run <= 1'b0;
         repeat (8) @(posedge clk_sys);
         #1;
      end
   endtask

   // Count cycles of the one-cycle word pulses
   always @(posedge clk_sys) begin
      if (tx_taken === 1'b1) begin
         n_taken <= n_taken + 1;
      end
      if (rx_valid === 1'b1) begin
         n_rxv <= n_rxv + 1;
      end
   end

   // Hang guard, well beyond the expected run length
   initial begin
      #300000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {resetn, run, strap_n, present_n} = 4'h3;
      tx_frame = 32'hA5C3_0F96;
      word_out = 32'h0000_0000;
      n_mismatch = 0;
      check_count = 0;
      do_reset();
      foreach (rows[k]) begin
         @(posedge clk_sys);
         {strap_n, present_n} <= rows[k][3:2];
         repeat (6) @(posedge clk_sys);
         #1;
         `CHK("one_wire_mode", rows[k][1], one_wire_mode)
         `CHK("present", rows[k][0], present)
      end
      // Two-wire: id and data on the receive wire, same frame
      strap_n <= 1'b1;
      do_reset();
      run_frame(32'h5A13_579B);
      `CHK("tx_word0", `SWL_TX_RESET, seen)
      `CHK("id_byte", 8'h5A, id_byte)
      `CHK("id_valid", 1'b1, id_valid)
      `CHK("rx_word0", 32'h5A13_579B, rx_frame)
      `CHK("state_up", swl_st_up, link_state)
      `CHK("taken_cnt0", 1, n_taken)
      `CHK("rxv_cnt0", 1, n_rxv)
      run_frame(32'hC3F0_2468);
      `CHK("tx_word1", 32'hA5C3_0F96, seen)
      `CHK("id_kept", 8'h5A, id_byte)
      `CHK("rx_word1", 32'hC3F0_2468, rx_frame)
      `CHK("taken_cnt1", 2, n_taken)
      `CHK("rxv_cnt1", 2, n_rxv)
      // Clock stopped: link falls back to idle
      repeat (260) @(posedge clk_sys);
      `CHK("state_idle", swl_st_idle, link_state)
      // One-wire: data on the shared wire, id on receive wire next frame
      strap_n <= 1'b0;
      tx_frame <= 32'h0FF0_1E2D;
      do_reset();
      run_frame(32'h3C69_ABCD);
      `CHK("ow_rx0", 32'hC396_5432, rx_frame)
      `CHK("ow_id_wait", 1'b0, id_valid)
      `CHK("ow_tx0", `SWL_TX_RESET, seen)
      run_frame(32'h96E1_7788);
      `CHK("ow_id", 8'h96, id_byte)
      `CHK("ow_tx1", 32'h0FF0_1E2D, seen)
      `CHK("ow_rx1", 32'h691E_8877, rx_frame)
      `CHK("ow_mode", 1'b1, one_wire_mode)
      `CHK("wire_misuse", 0, n_bad)
      give_verdict();
   end
endmodule
